// [src/flash_port_defs.svh]
// Purpose: constants for the parallel flash programming port
// Assumes: included by bare name
// Notes:   codes and phase selects as seen on the pins
`ifndef FLASH_PORT_DEFS_SVH
`define FLASH_PORT_DEFS_SVH
`define PHASE_COMMAND     4'h0
`define PHASE_ADDR_BYTE0  4'h1
`define PHASE_ADDR_BYTE1  4'h2
`define PHASE_ADDR_BYTE2  4'h3
`define PHASE_ADDR_BYTE3  4'h4
`define PHASE_DATA        4'h5
`define CODE_FLASH_READ   16'h0011
`define CODE_PAGE_WRITE   16'h0012
`define CODE_WRITE_LOCK   16'h0022
`define CODE_ERASE_WRITE  16'h0032
`define CODE_ERASE_LOCK   16'h0042
`define RESET_READY       1'b1
`define RESET_WORD_VALID  1'b1
`define COMMIT_CYCLES     8'h04
`endif

// [src/flash_port_pkg.sv]
// Purpose: shared types of the flash programming port
// Assumes: nothing
// Notes:   constants live in flash_port_defs.svh
package flash_port_pkg;
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DECODE  = 4'b0001,
		ST_FLUSH   = 4'b0010,
		ST_WAIT_OE = 4'b0011,
		ST_DRIVE   = 4'b0100,
		ST_HOLD    = 4'b0101,
		ST_TURN    = 4'b0110,
		ST_WAIT_HI = 4'b0111
	} port_state_t;
	typedef enum logic [1:0] {
		CMD_NONE  = 2'b00,
		CMD_READ  = 2'b01,
		CMD_WRITE = 2'b10
	} port_cmd_t;
endpackage

// [src/flash_mem_if.sv]
// Purpose: link between sequencer and flash array
// Assumes: single clock
// Notes:   commit is a one-cycle pulse carrying a page base
`timescale 1ns/1ns
interface flash_mem_if #(
	parameter int AW = 16,
	parameter int DW = 16,
	parameter int PW = 4
);
	logic          rd_en;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic          buf_wr;
	logic [PW-1:0] buf_idx;
	logic [DW-1:0] buf_data;
	logic          commit;
	logic [AW-1:0] commit_base;
	logic          busy;
	modport seq (output rd_en, rd_addr, buf_wr, buf_idx, buf_data, commit, commit_base, input rd_data, busy);
	modport mem (input rd_en, rd_addr, buf_wr, buf_idx, buf_data, commit, commit_base, output rd_data, busy);
endinterface

// [src/flash_page_store.sv]
// Purpose: flash array with a one-page load buffer
// Assumes: page buffer starts erased to all ones; array has no reset
// Notes:   commit copies the marked buffer words then holds busy
`timescale 1ns/1ns
`include "flash_port_defs.svh"
module flash_page_store #(
	parameter int AW = 16,
	parameter int DW = 16,
	parameter int PW = 4
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	flash_mem_if.mem  mem
);
	localparam int WORDS = 1 << AW;
	localparam int PAGE  = 1 << PW;
	typedef struct packed {
		logic [DW-1:0]     rd_data;
		logic [7:0]        wait_cnt;
		logic              busy;
		logic [PAGE-1:0]   mark;
		logic [PAGE*DW-1:0] page;
	} store_t;
	store_t        s_q;
	store_t        s_d;
	logic [DW-1:0] array_q [WORDS];
	always_comb begin
		s_d = s_q;
		if (mem.rd_en) begin
			s_d.rd_data = array_q[mem.rd_addr];
		end
		if (mem.buf_wr) begin
			s_d.page[mem.buf_idx*DW +: DW] = mem.buf_data;
			s_d.mark[mem.buf_idx] = 1'b1;
		end
		if (mem.commit) begin
			s_d.busy = 1'b1;
			s_d.wait_cnt = `COMMIT_CYCLES;
		end else if (s_q.busy) begin
			s_d.wait_cnt = s_q.wait_cnt - 8'h01;
			if (s_q.wait_cnt == 8'h01) begin
				s_d.busy = 1'b0;
				s_d.page = '1;
				s_d.mark = '0;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_q <= '{rd_data: '0, wait_cnt: 8'h00, busy: 1'b0, mark: '0, page: '1};
		end else begin
			s_q <= s_d;
		end
	end
	// Array carries no reset; only marked words are committed
	// so an unknown array never poisons untouched words
	always_ff @(posedge sys_clk) begin
		if (mem.commit) begin
			for (int i = 0; i < PAGE; i++) begin
				if (s_q.mark[i]) begin
					array_q[mem.commit_base + AW'(i)] <= s_q.page[i*DW +: DW];
				end
			end
		end
	end
	assign mem.rd_data = s_q.rd_data;
	assign mem.busy    = s_q.busy | mem.commit;
endmodule // flash_page_store

// [src/parallel_flash_program_port.sv]
// Purpose: device side of the parallel flash programming handshake
// Assumes: strobe and enable pins pass three flops, phase and data pins two; programmer obeys the handshake
// Notes:   DW 16 or 8; with 8 the address is four bytes
// Notes on behaviour
// - Capture phase and data on strobe low
// - Drop ready after capturing
// - Execute while waiting for strobe high
// - Enable low: drive word, then valid low
// - Enable high: release bus, raise valid
// - New command completes previous one first
// - Each data read returns word, advances pointer
// - Wide bus: two address phases
// - Narrow bus: four address phases, low first
// - Writes gather in a one-page buffer
// - Flush before touching another page
// - Flush on an accepted command phase when the buffer is dirty
// - Write codes, address, chained data writes
// - Phase select chooses latch target
// - Command word decodes read or write
`timescale 1ns/1ns
`include "flash_port_defs.svh"
module parallel_flash_program_port
	import flash_port_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 16,
	parameter int PW = 4
) (
	input  wire logic          sys_clk,
	input  wire logic          nrst,
	input  wire logic          prog_command_strobe_pin,
	input  wire logic          prog_output_enable_pin,
	input  wire logic [3:0]    prog_phase_select,
	input  wire logic [DW-1:0] prog_data_in,
	output logic      [DW-1:0] prog_data_out,
	output logic               prog_data_oe,
	output logic               prog_ready_pin,
	output logic               prog_word_valid_pin
);
	typedef struct packed {
		logic [2:0]    strobe_sync;
		logic [2:0]    oe_sync;
		logic [3:0]    phase_s1;
		logic [3:0]    phase_s2;
		logic [DW-1:0] data_s1;
		logic [DW-1:0] data_s2;
		logic          strobe_n;
		logic          oe_n;
		port_state_t   state;
		port_cmd_t     cmd;
		logic [3:0]    phase;
		logic [DW-1:0] word;
		logic [31:0]   addr;
		logic [AW-1:0] buf_page;
		logic          buf_dirty;
		logic          flush_new;
		logic          rd_en;
		logic          buf_wr;
		logic [PW-1:0] buf_idx;
		logic [DW-1:0] buf_data;
		logic          commit;
		logic [AW-1:0] commit_base;
		logic          ready;
		logic          valid_n;
		logic          drive;
		logic [DW-1:0] dout;
	} port_t;
	port_t q;
	port_t d;
	flash_mem_if #(.AW(AW), .DW(DW), .PW(PW)) mem ();
	flash_page_store #(.AW(AW), .DW(DW), .PW(PW)) u_store (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.mem     (mem.mem)
	);
	function automatic logic [AW-1:0] page_of(input logic [31:0] a);
		page_of = {a[AW-1:PW], {PW{1'b0}}};
	endfunction
	function automatic logic [31:0] put_byte(input logic [31:0] a, input logic [1:0] n,
	                                         input logic [DW-1:0] w);
		logic [31:0] r;
		r = a;
		if (DW == 16) begin
			if (n == 2'd0) r[15:0] = w[15:0];
			else if (n == 2'd1) r[31:16] = w[15:0];
		end else begin
			r[n*8 +: 8] = w[7:0];
		end
		put_byte = r;
	endfunction
	assign mem.rd_en       = q.rd_en;
	assign mem.rd_addr     = q.addr[AW-1:0];
	assign mem.buf_wr      = q.buf_wr;
	assign mem.buf_idx     = q.buf_idx;
	assign mem.buf_data    = q.buf_data;
	assign mem.commit      = q.commit;
	assign mem.commit_base = q.commit_base;
	always_comb begin
		d = q;
		d.strobe_sync = {q.strobe_sync[1:0], prog_command_strobe_pin};
		d.oe_sync     = {q.oe_sync[1:0], prog_output_enable_pin};
		d.phase_s1    = prog_phase_select;
		d.phase_s2    = q.phase_s1;
		d.data_s1     = prog_data_in;
		d.data_s2     = q.data_s1;
		if (q.strobe_sync[2] == q.strobe_sync[1]) d.strobe_n = q.strobe_sync[2];
		if (q.oe_sync[2] == q.oe_sync[1]) d.oe_n = q.oe_sync[2];
		d.rd_en  = 1'b0;
		d.buf_wr = 1'b0;
		d.commit = 1'b0;
		case (q.state)
			ST_IDLE: begin
				if (!q.strobe_n && q.ready) begin
					d.phase = q.phase_s2;
					d.word  = q.data_s2;
					d.ready = 1'b0;
					d.state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				if (q.phase == `PHASE_COMMAND) begin
					if (q.word == `CODE_FLASH_READ) begin
						d.cmd = CMD_READ;
					end else if (q.word == `CODE_PAGE_WRITE || q.word == `CODE_WRITE_LOCK ||
					             q.word == `CODE_ERASE_WRITE || q.word == `CODE_ERASE_LOCK) begin
						d.cmd = CMD_WRITE;
					end else begin
						d.cmd = CMD_NONE;
					end
					d.flush_new = q.buf_dirty;
					d.state = q.buf_dirty ? ST_FLUSH : ST_WAIT_HI;
				end else if (q.phase >= `PHASE_ADDR_BYTE0 && q.phase <= `PHASE_ADDR_BYTE3) begin
					d.addr  = put_byte(q.addr, 2'(q.phase - `PHASE_ADDR_BYTE0), q.word);
					d.state = ST_WAIT_HI;
				end else if (q.phase == `PHASE_DATA && q.cmd == CMD_READ) begin
					d.rd_en = 1'b1;
					d.state = ST_WAIT_OE;
				end else if (q.phase == `PHASE_DATA && q.cmd == CMD_WRITE) begin
					if (q.buf_dirty && page_of(q.addr) != q.buf_page) begin
						d.flush_new = 1'b0;
						d.state = ST_FLUSH;
					end else begin
						d.buf_wr    = 1'b1;
						d.buf_idx   = q.addr[PW-1:0];
						d.buf_data  = q.word;
						d.buf_page  = page_of(q.addr);
						d.buf_dirty = 1'b1;
						d.addr      = q.addr + 32'h1;
						d.state     = ST_WAIT_HI;
					end
				end else begin
					d.state = ST_WAIT_HI;
				end
			end
			ST_FLUSH: begin
				// Wait out any commit still running
				if (!mem.busy && q.buf_dirty) begin
					d.commit      = 1'b1;
					d.commit_base = q.buf_page;
					d.buf_dirty   = 1'b0;
				end else if (!mem.busy) begin
					d.state = q.flush_new ? ST_WAIT_HI : ST_DECODE;
				end
			end
			ST_WAIT_OE: begin
				// drive addressed word on enable low
				if (!q.oe_n) begin
					d.drive = 1'b1;
					d.dout  = mem.rd_data;
					d.state = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				d.valid_n = 1'b0;
				d.state   = ST_HOLD;
			end
			ST_HOLD: begin
				if (q.oe_n) begin
					d.drive = 1'b0;
					d.state = ST_TURN;
				end
			end
			ST_TURN: begin
				d.valid_n = 1'b1;
				d.addr  = q.addr + 32'h1;
				d.state = ST_WAIT_HI;
			end
			ST_WAIT_HI: begin
				if (q.strobe_n) begin
					d.ready = 1'b1;
					d.state = ST_IDLE;
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			q           <= '0;
			q.strobe_sync <= 3'b111;
			q.oe_sync   <= 3'b111;
			q.strobe_n  <= 1'b1;
			q.oe_n      <= 1'b1;
			q.state     <= ST_IDLE;
			q.cmd       <= CMD_NONE;
			q.ready     <= `RESET_READY;
			q.valid_n   <= `RESET_WORD_VALID;
			q.drive     <= 1'b0;
		end else begin
			q <= d;
		end
	end
	assign prog_data_out       = q.dout;
	assign prog_data_oe        = q.drive;
	assign prog_ready_pin      = q.ready;
	assign prog_word_valid_pin = q.valid_n;
endmodule // parallel_flash_program_port

// [tb/flash_port_sva.sv]
// Purpose: handshake checks at the port pins
// Assumes: bound into the port top module
// Notes:   delays follow the three-flop input sync
`timescale 1ns/1ns
module flash_port_sva #(
	parameter int DW = 16
) (
	input wire logic          sys_clk,
	input wire logic          nrst,
	input wire logic          prog_command_strobe_pin,
	input wire logic          prog_output_enable_pin,
	input wire logic [3:0]    prog_phase_select,
	input wire logic [DW-1:0] prog_data_in,
	input wire logic [DW-1:0] prog_data_out,
	input wire logic          prog_data_oe,
	input wire logic          prog_ready_pin,
	input wire logic          prog_word_valid_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_RST: assert property (disable iff (1'b0)
		!nrst |=> prog_ready_pin && prog_word_valid_pin && !prog_data_oe) else $error("reset state wrong");
	AST_CAPTURE: assert property (
		$fell(prog_ready_pin) |-> !$past(prog_command_strobe_pin) && !$past(prog_command_strobe_pin, 2))
		else $error("ready fell without strobe");
	AST_DONE: assert property (
		$rose(prog_ready_pin) |-> prog_command_strobe_pin && $past(prog_command_strobe_pin, 2))
		else $error("ready rose while strobe low");
	AST_BOUND: assert property (
		$rose(prog_command_strobe_pin) |-> ##[1:40] prog_ready_pin) else $error("ready did not return");
	AST_OE_CAUSE: assert property (
		$rose(prog_data_oe) |-> !$past(prog_output_enable_pin, 2) && !prog_ready_pin)
		else $error("bus driven without enable");
	AST_VALID_NEXT: assert property (
		$rose(prog_data_oe) |=> !prog_word_valid_pin) else $error("valid late");
	AST_VALID_OE: assert property (
		!prog_word_valid_pin && !$fell(prog_data_oe) |-> prog_data_oe && !prog_ready_pin)
		else $error("valid without drive");
	AST_RELEASE: assert property (
		$fell(prog_data_oe) |-> $past(prog_output_enable_pin, 2) ##1 prog_word_valid_pin)
		else $error("bus release wrong");
	AST_HOLD_OUT: assert property (
		prog_data_oe && $past(prog_data_oe) |-> $stable(prog_data_out)) else $error("read word moved");
	cover property ($rose(prog_ready_pin));
	cover property ($rose(prog_data_oe) ##1 !prog_word_valid_pin);
	cover property ($fell(prog_data_oe) ##1 prog_word_valid_pin);
endmodule // flash_port_sva
bind parallel_flash_program_port flash_port_sva #(.DW(DW)) chk_u (.sys_clk, .nrst, .prog_command_strobe_pin,
	.prog_output_enable_pin, .prog_phase_select, .prog_data_in, .prog_data_out, .prog_data_oe,
	.prog_ready_pin, .prog_word_valid_pin);

// [tb/flash_programmer.sv]
// Purpose: behavioural external programmer
// Assumes: drives on the falling edge
// Notes:   gap slows every step; bus pulled up
`timescale 1ns/1ns
module flash_programmer #(
	parameter int DW = 16
) (
	input  wire logic          sys_clk,
	input  wire logic [DW-1:0] prog_data_out,
	input  wire logic          prog_data_oe,
	input  wire logic          prog_ready_pin,
	input  wire logic          prog_word_valid_pin,
	output logic               prog_command_strobe_pin = 1'b1,
	output logic               prog_output_enable_pin = 1'b1,
	output logic [3:0]         prog_phase_select = 4'hF,
	output logic [DW-1:0]      prog_data_in
);
	logic          drv = 1'b0;
	logic [DW-1:0] val = '0;
	int            gap = 0;
	// Undriven bus floats to the pull-up level
	assign prog_data_in = prog_data_oe ? prog_data_out : (drv ? val : '1);
	task automatic start(input logic [3:0] p, input logic [DW-1:0] d);
		while (!prog_ready_pin) @(negedge sys_clk);
		prog_phase_select = p;
		val = d;
		drv = 1'b1;
		repeat (3 + gap) @(negedge sys_clk);
		prog_command_strobe_pin = 1'b0;
		while (prog_ready_pin) @(negedge sys_clk);
	endtask
	task automatic finish();
		drv = 1'b0;
		prog_phase_select = 4'hF;
		repeat (1 + gap) @(negedge sys_clk);
		prog_command_strobe_pin = 1'b1;
		while (!prog_ready_pin) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] p, input logic [DW-1:0] d);
		start(p, d);
		finish();
	endtask
	task automatic rd(output logic [DW-1:0] w);
		start(4'h5, '0);
		drv = 1'b0;
		repeat (1 + gap) @(negedge sys_clk);
		prog_output_enable_pin = 1'b0;
		while (prog_word_valid_pin) @(negedge sys_clk);
		w = prog_data_in;
		prog_output_enable_pin = 1'b1;
		while (!prog_word_valid_pin) @(negedge sys_clk);
		drv = 1'b1;
		@(negedge sys_clk);
		finish();
	endtask
endmodule // flash_programmer

// [tb/tb_top.sv]
// Purpose: self-checking bench of the programming port
// Assumes: 16-bit bus build
// Notes:   flash is unreset, so only written words are read
`timescale 1ns/1ns
`include "flash_port_defs.svh"
`define CHK(nm, ex, got) num_checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end
module tb_top;
	import flash_port_pkg::*;
	logic        sys_clk, nrst;
	wire         prog_command_strobe_pin, prog_output_enable_pin, prog_data_oe;
	wire         prog_ready_pin, prog_word_valid_pin;
	wire  [3:0]  prog_phase_select;
	wire  [15:0] prog_data_in, prog_data_out;
	int          error_cnt = 0, num_checks = 0, cyc = 0;
	logic [15:0] code [4] = '{`CODE_PAGE_WRITE, `CODE_WRITE_LOCK, `CODE_ERASE_WRITE, `CODE_ERASE_LOCK};
	logic [15:0] w;
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	parallel_flash_program_port #(.DW(16)) dut_u (.sys_clk, .nrst, .prog_command_strobe_pin,
		.prog_output_enable_pin, .prog_phase_select, .prog_data_in, .prog_data_out, .prog_data_oe,
		.prog_ready_pin, .prog_word_valid_pin);
	flash_programmer #(.DW(16)) prog_u (.sys_clk, .prog_data_out, .prog_data_oe, .prog_ready_pin,
		.prog_word_valid_pin, .prog_command_strobe_pin, .prog_output_enable_pin, .prog_phase_select,
		.prog_data_in);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Stall detector ends a hung run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic t_reset();
		nrst = 1'b0;
		repeat (16) @(negedge sys_clk);
		`CHK("ready", 1'b1, prog_ready_pin)
		`CHK("valid_n", 1'b1, prog_word_valid_pin)
		`CHK("oe", 1'b0, prog_data_oe)
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		$display("test reset done");
	endtask
	// Two words per code, second one on the next page
	task automatic t_write();
		for (int i = 0; i < 4; i++) begin
			prog_u.wr(`PHASE_COMMAND, code[i]);
			prog_u.wr(`PHASE_ADDR_BYTE0, 16'(16'h003F + 16 * i));
			prog_u.wr(`PHASE_ADDR_BYTE1, 16'h0000);
			prog_u.wr(`PHASE_DATA, 16'(16'hA500 + 2 * i));
			prog_u.wr(`PHASE_DATA, 16'(16'hA501 + 2 * i));
		end
		$display("test write done");
	endtask
	// Read after write forces the last page out first
	task automatic t_read();
		prog_u.wr(`PHASE_COMMAND, `CODE_FLASH_READ);
		for (int i = 0; i < 4; i++) begin
			prog_u.wr(`PHASE_ADDR_BYTE0, 16'(16'h003F + 16 * i));
			prog_u.wr(`PHASE_ADDR_BYTE1, 16'h0000);
			prog_u.wr(4'h7, 16'h0000);
			for (int j = 0; j < 2; j++) begin
				prog_u.rd(w);
				`CHK("word", 16'(16'hA500 + 2 * i + j), w)
			end
		end
		$display("test read done");
	endtask
	initial begin
		nrst = 1'b0;
		t_reset();
		t_write();
		t_read();
		prog_u.gap = 3;
		t_reset();
		t_read();
		report_and_stop();
	end
endmodule // tb_top
